//--- rtl/fcss_seq.sv
`default_nettype none

// Behaviour
// R01 - Rising start edge puts all four sample holders into hold together.
// R02 - Holders stay in hold while all four channels are converted.
// R03 - The start edge begins channel 1; its result goes to result one.
// R04 - Each stored result starts the next channel, strictly channel 1 to 4.
// R05 - After channel 4 is stored the active-low completion flag goes low.
// R06 - Start input is asynchronous and synchronised inside the device.
// R07 - Host does not start again before all four conversions complete; the bench starts once mid-sequence on purpose.
// R08 - Host gates start from a strobe, never a bare address decode.
// R09 - Host reads results with four reads to one address; no address pins.
// R10 - First read returns result one, second result two, up to four.
// R11 - Completion flag returns high at the first read strobe fall.
// R12 - Every accepted start edge resets the read pointer to result one.
// R13 - Host does not read during a conversion; it waits for the flag.
// R14 - Results are 12-bit two's complement, one step is span over 4096.
// R15 - Half a step below ground sits between all-ones and all-zeros codes.
// R16 - Top transition separates 0x7FE from 0x7FF.
// R17 - Bottom transition separates 0x800 from 0x801.
// R18 - Data outputs are driven only while read strobe and select are low.
// R19 - A full sequence takes 78 or 79 conversion clock edges.
// R20 - External clock is used; a stuck clock pin selects the internal oscillator.
// R21 - Result appears on three-state outputs, bit 11 most significant.
// R22 - A start edge during a running sequence is ignored.
module fcss_seq (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Conversion control pins
    input wire logic conversion_start_n_i,
    input wire logic conv_clk_i,
    output logic conv_done_n_o,
    output logic [fcss_pkg::NUM_CH-1:0] hold_o,
    // Analog samples in half-step units
    input wire logic signed [fcss_pkg::AIN_W-1:0] analog_input_one_i,
    input wire logic signed [fcss_pkg::AIN_W-1:0] analog_input_two_i,
    input wire logic signed [fcss_pkg::AIN_W-1:0] analog_input_three_i,
    input wire logic signed [fcss_pkg::AIN_W-1:0] analog_input_four_i,
    // Host read port
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    output logic [fcss_pkg::RES_W-1:0] data_o,
    output logic data_oe_o
);
    import fcss_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic start_s1_q, start_s2_q, start_s3_q;
    logic clk_s1_q, clk_s2_q, clk_s3_q;
    logic cs_s1_q, cs_s2_q, rd_s1_q, rd_s2_q;
    logic signed [AIN_W-1:0] ain_s1_q [NUM_CH];
    logic signed [AIN_W-1:0] ain_s2_q [NUM_CH];
    logic signed [AIN_W-1:0] ain_pin [NUM_CH];
    logic start_rise;

    assign ain_pin[0] = analog_input_one_i;
    assign ain_pin[1] = analog_input_two_i;
    assign ain_pin[2] = analog_input_three_i;
    assign ain_pin[3] = analog_input_four_i;

    // Reset loads the idle level of each control pin, so no false edge follows reset; the analog sample stages are not reset.
    // The start pin must therefore be high while reset is applied.
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            start_s1_q <= 1'b1;
            start_s2_q <= 1'b1;
            start_s3_q <= 1'b1;
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            rd_s1_q <= 1'b1;
            rd_s2_q <= 1'b1;
        end else begin
            start_s1_q <= conversion_start_n_i; // see R06
            start_s2_q <= start_s1_q;
            start_s3_q <= start_s2_q;
            cs_s1_q <= cs_n_i;
            cs_s2_q <= cs_s1_q;
            rd_s1_q <= rd_n_i;
            rd_s2_q <= rd_s1_q;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_s3_q <= 1'b0;
        end else begin
            clk_s1_q <= conv_clk_i;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
        end
    end

    // Samples travel the same two stages as the start pin, so all four are taken
    // at the very cycle the start edge is seen.
    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < NUM_CH; i++) begin
            ain_s1_q[i] <= ain_pin[i];
            ain_s2_q[i] <= ain_s1_q[i];
        end
    end

    assign start_rise = start_s2_q && !start_s3_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Conversion clock selection.

    // Counter widths follow the cycle counts, so a slower oscillator only needs
    // new package constants.
    localparam int unsigned LOSS_W = $clog2(CLK_LOSS_CYC + 1);
    localparam int unsigned DIV_W = $clog2(INT_DIV_CYC);

    logic [LOSS_W-1:0] loss_cnt_q;
    logic [DIV_W-1:0] div_cnt_q;
    logic ext_rise;
    logic use_int;
    logic int_tick;
    logic conv_en;

    assign ext_rise = clk_s2_q && !clk_s3_q;
    assign use_int = (loss_cnt_q == LOSS_W'(CLK_LOSS_CYC));
    assign int_tick = (div_cnt_q == DIV_W'(INT_DIV_CYC - 1));
    assign conv_en = use_int ? int_tick : ext_rise; // see R20

    // A clock pin held at the negative rail never toggles; that is what hands
    // the sequence over to the internal oscillator.
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            loss_cnt_q <= '0;
        end else if (ext_rise) begin
            loss_cnt_q <= '0;
        end else if (!use_int) begin
            loss_cnt_q <= LOSS_W'(loss_cnt_q + 1'b1); // see R20
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i || int_tick) begin
            div_cnt_q <= '0;
        end else begin
            div_cnt_q <= DIV_W'(div_cnt_q + 1'b1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer.

    fcss_state_t state_q;
    logic [CH_W-1:0] ch_q;
    logic [EDGE_W-1:0] edge_q;
    logic signed [AIN_W-1:0] held_q [NUM_CH];
    logic [NUM_CH-1:0] hold_q;
    logic start_acc;
    logic push_valid;
    logic push_ready;
    logic push_fire;
    logic last_push;
    logic [RES_W-1:0] push_data;

    assign start_acc = start_rise && (state_q == FCSS_IDLE); // see R22
    assign push_valid = (state_q == FCSS_PUSH);
    assign push_fire = push_valid && push_ready;
    assign last_push = push_fire && (ch_q == CH_W'(NUM_CH - 1));
    assign push_data = fcss_quantize(held_q[ch_q]); // see R14 see R15 see R16 see R17

    always_ff @(posedge mclk_i) begin
        if (start_acc) begin
            for (int i = 0; i < NUM_CH; i++) begin
                held_q[i] <= ain_s2_q[i]; // see R01
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            state_q <= FCSS_IDLE;
            ch_q <= '0;
            edge_q <= '0;
        end else begin
            case (state_q)
                FCSS_IDLE: begin
                    if (start_acc) begin
                        state_q <= FCSS_CONV; // see R03
                        ch_q <= '0;
                        edge_q <= '0;
                    end
                end
                FCSS_CONV: begin
                    if (conv_en) begin
                        edge_q <= EDGE_W'(edge_q + 1'b1);
                        if (EDGE_W'(edge_q + 1'b1) == fcss_ch_end(ch_q)) begin
                            state_q <= FCSS_PUSH; // see R19
                        end
                    end
                end
                FCSS_PUSH: begin
                    if (push_ready) begin
                        if (last_push) begin
                            state_q <= FCSS_IDLE;
                        end else begin
                            ch_q <= CH_W'(ch_q + 1'b1); // see R04
                            state_q <= FCSS_CONV;
                        end
                    end
                end
                default: begin
                    state_q <= FCSS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            hold_q <= HOLD_RST;
        end else if (start_acc) begin
            hold_q <= HOLD_ALL; // see R01 see R02
        end else if (last_push) begin
            hold_q <= HOLD_RST;
        end
    end

    assign hold_o = hold_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Result store and host read port.

    logic acc_q;
    logic acc;
    logic acc_rise;
    logic pop_valid;
    logic [RES_W-1:0] pop_data;
    logic pop;
    logic [RES_W-1:0] dout_q;
    logic oe_q;
    logic done_n_q;

    assign acc = !cs_s2_q && !rd_s2_q;
    assign acc_rise = acc && !acc_q;
    assign pop = acc_rise && pop_valid; // see R09 see R10

    // The store is read in write order, so the read pointer is implicit; an
    // accepted start flushes it, which is the pointer returning to result one.
    fcss_fifo #(
        .WIDTH(RES_W),
        .DEPTH(FIFO_DEPTH)
    ) u_store (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .flush_i(start_acc), // see R12
        .wr_valid_i(push_valid),
        .wr_ready_o(push_ready),
        .wr_data_i(push_data),
        .rd_valid_o(pop_valid),
        .rd_ready_i(pop),
        .rd_data_o(pop_data)
    );

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            acc_q <= 1'b0;
            oe_q <= 1'b0;
            dout_q <= DOUT_RST;
        end else begin
            acc_q <= acc;
            oe_q <= acc; // see R18
            if (pop) begin
                dout_q <= pop_data; // see R21
            end
        end
    end

    // Completion wins over a read strobe fall arriving in the same cycle.
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            done_n_q <= DONE_N_RST;
        end else if (last_push) begin
            done_n_q <= 1'b0; // see R05
        end else if (acc_rise || start_acc) begin
            done_n_q <= 1'b1; // see R11
        end
    end

    assign data_o = dout_q;
    assign data_oe_o = oe_q;
    assign conv_done_n_o = done_n_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_accept;
        start_rise && (state_q == FCSS_IDLE);
    endsequence

    sequence s_last;
        push_fire && (ch_q == 2'd3);
    endsequence

    chk_hold_at_start: assert property (s_accept |=> hold_o == 4'hF) // see R01
        else $error("holders not in hold after start");
    chk_hold_while_busy: assert property ((state_q != FCSS_IDLE) |-> hold_o == 4'hF) // see R02
        else $error("holder left hold during sequence");
    chk_first_channel: assert property (s_accept |=> (ch_q == 2'd0) && (edge_q == 7'd0)) // see R03
        else $error("sequence did not begin at channel one");
    chk_channel_order: assert property (push_fire && (ch_q != 2'd3) |=> ch_q == $past(ch_q) + 2'd1) // see R04
        else $error("channel order broken");
    chk_done_after_last: assert property (s_last |=> !conv_done_n_o && hold_o == 4'h0) // see R05
        else $error("completion flag not raised after last result");
    chk_start_sync_path: assert property ($rose(start_s2_q) && (state_q == FCSS_IDLE) |=> state_q == FCSS_CONV) // see R06
        else $error("synchronised start edge not taken");
    chk_done_release: assert property (acc_rise && !last_push |=> conv_done_n_o) // see R11
        else $error("completion flag not released by read");
    chk_pointer_reset: assert property (s_accept |=> !pop_valid ##1 !pop_valid) // see R12
        else $error("result store not reset by start");
    chk_out_gate: assert property (data_oe_o |-> $past(acc)) // see R18
        else $error("data driven outside a read");
    chk_seq_length: assert property (s_last |-> edge_q == 7'd78) // see R19
        else $error("sequence length not 78 edges");
    chk_int_clock: assert property (use_int && (state_q == FCSS_CONV) && int_tick |=> edge_q != $past(edge_q) || state_q != FCSS_CONV) // see R20
        else $error("internal oscillator does not advance sequence");
    chk_busy_ignore: assert property (start_rise && (state_q == FCSS_CONV) |=> ch_q == $past(ch_q) && hold_o == 4'hF) // see R22
        else $error("start during sequence disturbed it");
    chk_read_pop: assert property (pop |=> data_o == $past(pop_data)) // see R10
        else $error("read did not take the head result");

    // The flag must stay low until a read or a start, and the output enable must let go;
    // a flag let go early or a stuck enable would upset the host's interrupt or bus.
    chk_done_stays_low: assert property (!conv_done_n_o && !acc_rise && !start_acc |=> !conv_done_n_o) // see R05
        else $error("completion flag released without read or start");
    chk_oe_release: assert property (!acc |=> !data_oe_o) // see R18
        else $error("data still driven after strobe release");
    chk_empty_read: assert property (acc_rise && !pop_valid |=> data_o == $past(data_o)) // see R10
        else $error("read with no result left changed data");
    chk_track_idle: assert property ((state_q == FCSS_IDLE) |-> hold_o == 4'h0) // see R02
        else $error("holder not tracking while idle");

endmodule : fcss_seq

`default_nettype wire

//--- rtl/fcss_pkg.sv
`default_nettype none

package fcss_pkg;

    // Clocking of the control logic and of the internal conversion oscillator.
    localparam int unsigned MCLK_PERIOD_NS = 10;
    localparam int unsigned INT_OSC_PERIOD_NS = 400;
    localparam int unsigned INT_DIV_CYC = (INT_OSC_PERIOD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    // Cycles without an external clock edge before the internal oscillator takes over.
    localparam int unsigned CLK_LOSS_CYC = 4 * INT_DIV_CYC;

    // Channels, result width and analog sample width in half-step units.
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned CH_W = 2;
    localparam int unsigned RES_W = 12;
    localparam int unsigned AIN_W = 15;
    localparam int unsigned FIFO_DEPTH = 8;

    // Conversion clock edges of one sequence.
    localparam int unsigned SEQ_LEAD_EDGES = 2;
    localparam int unsigned CH_EDGES = 19;
    localparam int unsigned SEQ_EDGES = SEQ_LEAD_EDGES + NUM_CH * CH_EDGES;
    localparam int unsigned EDGE_W = 7;

    // Code limits and values after reset.
    localparam logic signed [AIN_W:0] CODE_HI = 16'sh07FF;
    localparam logic signed [AIN_W:0] CODE_LO = 16'shF800;
    localparam logic [RES_W-1:0] CODE_MAX = 12'h7FF;
    localparam logic [RES_W-1:0] CODE_MIN = 12'h800;
    localparam logic [RES_W-1:0] DOUT_RST = 12'h000;
    localparam logic [NUM_CH-1:0] HOLD_ALL = 4'hF;
    localparam logic [NUM_CH-1:0] HOLD_RST = 4'h0;
    localparam logic DONE_N_RST = 1'b1;

    typedef enum logic [1:0] {
        FCSS_IDLE = 2'b00,
        FCSS_CONV = 2'b01,
        FCSS_PUSH = 2'b10
    } fcss_state_t;

    // Round a half-step sample to the nearest code, clamped to the 12-bit range.
    function automatic logic [RES_W-1:0] fcss_quantize(input logic signed [AIN_W-1:0] h);
        logic signed [AIN_W:0] r;
        r = ($signed({h[AIN_W-1], h}) + 16'sh0001) >>> 1;
        if (r > CODE_HI) begin
            return CODE_MAX;
        end else if (r < CODE_LO) begin
            return CODE_MIN;
        end
        return r[RES_W-1:0];
    endfunction : fcss_quantize

    // Edge count of the sequence at which a channel's result is ready.
    function automatic logic [EDGE_W-1:0] fcss_ch_end(input logic [CH_W-1:0] ch);
        return EDGE_W'(SEQ_LEAD_EDGES + (32'(ch) + 1) * CH_EDGES);
    endfunction : fcss_ch_end

endpackage : fcss_pkg

`default_nettype wire

//--- rtl/fcss_fifo.sv
`default_nettype none

module fcss_fifo #(
    parameter int unsigned WIDTH = 12,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic flush_i,
    // Fill side
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    input wire logic [WIDTH-1:0] wr_data_i,
    // Drain side
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic [WIDTH-1:0] rd_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [AW-1:0] rptr_d;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic valid_q;
    logic [WIDTH-1:0] head_q;
    logic wr_fire;
    logic rd_fire;

    assign wr_ready_o = (cnt_q != (AW+1)'(DEPTH));
    assign rd_valid_o = valid_q;
    assign rd_data_o = head_q;
    assign wr_fire = wr_valid_i && wr_ready_o && !flush_i;
    assign rd_fire = rd_ready_i && valid_q && !flush_i;

    always_comb begin
        rptr_d = rptr_q;
        cnt_d = cnt_q;
        if (flush_i) begin
            rptr_d = '0;
            cnt_d = '0;
        end else begin
            if (rd_fire) begin
                rptr_d = AW'(rptr_q + 1'b1);
            end
            cnt_d = (AW+1)'(cnt_q + {{AW{1'b0}}, wr_fire} - {{AW{1'b0}}, rd_fire});
        end
    end

    always_ff @(posedge mclk_i) begin
        if (wr_fire) begin
            mem_q[wptr_q] <= wr_data_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q <= '0;
        end else begin
            rptr_q <= rptr_d;
            cnt_q <= cnt_d;
            if (flush_i) begin
                wptr_q <= '0;
            end else if (wr_fire) begin
                wptr_q <= AW'(wptr_q + 1'b1);
            end
        end
    end

    // The head word is bypassed from the write port so valid and data line up.
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            valid_q <= 1'b0;
            head_q <= '0;
        end else begin
            valid_q <= (cnt_d != '0);
            if (wr_fire && (wptr_q == rptr_d)) begin
                head_q <= wr_data_i;
            end else begin
                head_q <= mem_q[rptr_d];
            end
        end
    end

endmodule : fcss_fifo

`default_nettype wire

//--- test/fcss_host.sv
`default_nettype none

module fcss_host (
    // Clock
    input wire logic mclk_i,
    // Pins towards the converter
    output logic conversion_start_n_o,
    output logic conv_clk_o,
    output logic cs_n_o,
    output logic rd_n_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic run_clk = 1'b1;
    int unsigned edges = 0;
    int unsigned ph = 0;

    initial begin
        conversion_start_n_o = 1'b1;
        conv_clk_o = 1'b0;
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The external conversion clock runs free, 10 mclk a period.
    // Stopping it leaves the pin still, so the converter falls back to its own oscillator.
    always @(posedge mclk_i) begin
        if (run_clk) begin
            ph <= (ph == 4) ? 0 : ph + 1;
            if (ph == 4) begin
                conv_clk_o <= ~conv_clk_o;
                edges <= edges + (conv_clk_o ? 0 : 1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The start pulse comes from a timed strobe, long enough for the synchroniser.
    // Its rise is kept clear of a clock rise so the edge count is unambiguous.
    task automatic pulse_start(output int unsigned snap);
        @(posedge mclk_i);
        conversion_start_n_o <= 1'b0;
        repeat (4) @(posedge mclk_i);
        while (run_clk && ph != 2) begin
            @(posedge mclk_i);
        end
        conversion_start_n_o <= 1'b1;
        snap = edges;
    endtask : pulse_start

    // Every read goes to the one address; sel_n high leaves the chip deselected.
    task automatic strobe(input logic sel_n);
        @(posedge mclk_i);
        cs_n_o <= sel_n;
        rd_n_o <= 1'b0;
        repeat (6) @(posedge mclk_i);
    endtask : strobe

    task automatic release_bus();
        @(posedge mclk_i);
        cs_n_o <= 1'b1;
        rd_n_o <= 1'b1;
        repeat (6) @(posedge mclk_i);
    endtask : release_bus

endmodule : fcss_host

`default_nettype wire

//--- test/tb_top.sv
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fcss_pkg::*;

    typedef struct {
        logic signed [AIN_W-1:0] a [NUM_CH];
        logic [RES_W-1:0] e [NUM_CH];
    } fcss_row_t;

    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic signed [AIN_W-1:0] ain [NUM_CH];
    logic start_n, cclk, cs_n, rd_n, done_n, oe;
    logic [NUM_CH-1:0] hold;
    logic [RES_W-1:0] data;
    int n_errors = 0;
    int n_tests = 0;
    fcss_row_t rows [3];

    always #5 mclk = ~mclk;

    fcss_host fcss_host_i (.mclk_i(mclk), .conversion_start_n_o(start_n), .conv_clk_o(cclk),
        .cs_n_o(cs_n), .rd_n_o(rd_n));

    fcss_seq fcss_seq_i (.mclk_i(mclk), .rstn_i(rstn), .conversion_start_n_i(start_n),
        .conv_clk_i(cclk), .conv_done_n_o(done_n), .hold_o(hold),
        .analog_input_one_i(ain[0]), .analog_input_two_i(ain[1]),
        .analog_input_three_i(ain[2]), .analog_input_four_i(ain[3]),
        .cs_n_i(cs_n), .rd_n_i(rd_n), .data_o(data), .data_oe_o(oe));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic note(input bit ok, input string what);
        n_tests++;
        if (!ok) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : note

    task automatic cmp_flag(input logic got, input logic exp, input string what);
        note(got === exp, what);
    endtask : cmp_flag

    task automatic cmp_hold(input logic [NUM_CH-1:0] got, input logic [NUM_CH-1:0] exp);
        note(got === exp, "track/hold state");
    endtask : cmp_hold

    task automatic cmp_word(input logic [RES_W-1:0] got, input logic [RES_W-1:0] exp);
        note(got === exp, "result word");
    endtask : cmp_word

    task automatic cmp_edges(input int unsigned n);
        note(n == 78 || n == 79, "conversion clock edges per sequence");
    endtask : cmp_edges

    // Waits for completion; the holders must stay in hold all the way.
    task automatic wait_done(input int bound, output bit ok);
        ok = 1'b1;
        for (int i = 0; i < bound && done_n !== 1'b0; i++) begin
            @(posedge mclk);
            #1;
            if (done_n !== 1'b0 && hold !== HOLD_ALL) begin
                ok = 1'b0;
            end
        end
        if (done_n !== 1'b0) begin
            note(1'b0, "completion flag timeout");
            end_sim();
        end
    endtask : wait_done

    // The bench starts only when idle and reads only after completion; a second
    // start in mid-sequence is made on purpose when dbl is set.
    task automatic run_seq(input int r, input bit ext, input bit dbl, input int bound);
        int unsigned s;
        int unsigned s2;
        bit ok;
        @(posedge mclk);
        for (int c = 0; c < NUM_CH; c++) begin
            ain[c] <= rows[r].a[c];
        end
        fcss_host_i.pulse_start(s);
        repeat (5) @(posedge mclk);
        #1;
        cmp_hold(hold, HOLD_ALL);
        if (dbl) begin
            repeat (200) @(posedge mclk);
            for (int c = 0; c < NUM_CH; c++) begin
                ain[c] <= rows[r + 1].a[c];
            end
            fcss_host_i.pulse_start(s2);
        end
        wait_done(bound, ok);
        cmp_flag(ok, 1'b1, "hold during sequence");
        if (ext) begin
            cmp_edges(fcss_host_i.edges - s);
        end
        #1;
        cmp_hold(hold, HOLD_RST);
    endtask : run_seq

    // Reads past the fourth word find the last value again.
    task automatic read_row(input int r, input int n);
        for (int k = 0; k < n; k++) begin
            fcss_host_i.strobe(1'b0);
            #1;
            cmp_flag(oe, 1'b1, "output enable during read");
            cmp_word(data, rows[r].e[k < NUM_CH ? k : NUM_CH - 1]);
            if (k == 0) begin
                cmp_flag(done_n, 1'b1, "flag after first read");
            end
            fcss_host_i.release_bus();
            #1;
            cmp_flag(oe, 1'b0, "output enable after read");
        end
    endtask : read_row

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ain = '{default: '0};
        // Half-step inputs beside their codes: mid-scale, top and bottom transitions, clamps.
        rows[0] = '{a: '{15'h7FFF, 15'h7FFE, 15'h0FFD, 15'h0FFC},
                    e: '{12'h000, 12'hFFF, 12'h7FF, 12'h7FE}};
        rows[1] = '{a: '{15'h7001, 15'h7000, 15'h0000, 15'h0001},
                    e: '{12'h801, 12'h800, 12'h000, 12'h001}};
        rows[2] = '{a: '{15'h2328, 15'h5CD8, 15'h0002, 15'h0003},
                    e: '{12'h7FF, 12'h800, 12'h001, 12'h002}};
        repeat (5) @(posedge mclk);
        #1;
        cmp_flag(done_n, DONE_N_RST, "flag in reset");
        cmp_hold(hold, HOLD_RST);
        cmp_flag(oe, 1'b0, "enable in reset");
        @(posedge mclk);
        rstn <= 1'b1;
        $display("test reset done");
        for (int r = 0; r < 3; r++) begin
            run_seq(r, 1'b1, 1'b0, 1000);
            read_row(r, NUM_CH);
            $display("test row %0d done", r);
        end
        run_seq(0, 1'b1, 1'b1, 1000);
        read_row(0, NUM_CH);
        $display("test start while busy done");
        run_seq(1, 1'b1, 1'b0, 1000);
        read_row(1, 2);
        run_seq(2, 1'b1, 1'b0, 1000);
        read_row(2, NUM_CH + 1);
        $display("test pointer restart done");
        fcss_host_i.strobe(1'b1);
        #1;
        cmp_flag(oe, 1'b0, "enable without select");
        fcss_host_i.release_bus();
        $display("test deselected read done");
        @(posedge mclk);
        fcss_host_i.run_clk <= 1'b0;
        repeat (170) @(posedge mclk);
        run_seq(0, 1'b0, 1'b0, 4000);
        read_row(0, NUM_CH);
        $display("test internal oscillator done");
        end_sim();
    end

endmodule : tb_top

`default_nettype wire
